// >>> core/mbt_cfg.svh
`ifndef MBT_CFG_SVH
`define MBT_CFG_SVH

// Sizes
`define MBT_UNITS 16
`define MBT_MEM_BYTES 512
`define MBT_CNT_MIN 16'h0001
`define MBT_CNT_MAX 16'h00c0

// Register map
`define MBT_STATUS_OFS 16'h0000
`define MBT_UNIT_PAGE 8'h01
`define MBT_REG_CTRL 2'h0
`define MBT_REG_SRC 2'h1
`define MBT_REG_DST 2'h2
`define MBT_REG_CNT 2'h3
`define MBT_MEM_BASE 16'h1000

// Control field layout and reset value
`define MBT_CTRL_W 12
`define MBT_CTRL_COPY_BIT 0
`define MBT_CTRL_SHOW_BIT 1
`define MBT_CTRL_RST 12'h002

`endif

// >>> core/mbt_pkg.sv
package mbt_pkg;

   typedef logic [15:0] mbt_val_t;

   typedef enum logic [1:0] {
      MBT_KIND_CONST = 2'b00,
      MBT_KIND_MARKER = 2'b01,
      MBT_KIND_UNITVAL = 2'b10
   } mbt_kind_t;

   typedef enum logic [1:0] {
      MBT_W_BYTE = 2'b00,
      MBT_W_WORD = 2'b01,
      MBT_W_DWORD = 2'b10
   } mbt_width_t;

   typedef struct packed {
      logic [1:0] cnt_kind;
      logic [1:0] dst_w;
      logic [1:0] dst_kind;
      logic [1:0] src_w;
      logic [1:0] src_kind;
      logic show;
      logic copy;
   } mbt_ctrl_t;

   typedef struct packed {
      mbt_val_t src;
      mbt_val_t dst;
      mbt_val_t cnt;
   } mbt_opnd_t;

   typedef struct packed {
      logic range;
      logic overlap;
      logic bad;
   } mbt_flags_t;

   typedef enum logic {
      MBT_IDLE = 1'b0,
      MBT_MOVE = 1'b1
   } mbt_state_t;

endpackage

// >>> core/mbt_unit.sv
`timescale 1ns/1ps
`include "mbt_cfg.svh"

module mbt_unit #(
   parameter int MEM_BYTES = `MBT_MEM_BYTES,
   parameter int AW = 9
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Settings
   input wire mbt_pkg::mbt_ctrl_t cfg,
   input wire mbt_pkg::mbt_opnd_t opnd,
   input wire mbt_pkg::mbt_val_t [`MBT_UNITS-1:0] ext_value,
   input wire logic [7:0] cnt_byte,
   // Results
   output logic [AW-1:0] cnt_idx,
   output logic [AW-1:0] src_addr,
   output logic [AW-1:0] dst_addr,
   output logic [7:0] len,
   output mbt_pkg::mbt_flags_t flags_q,
   output logic err_now
);
   import mbt_pkg::*;

   localparam logic [17:0] MEM_L = 18'(MEM_BYTES);

   function automatic mbt_val_t pick_val(input logic [1:0] kind, input mbt_val_t v,
                                         input mbt_val_t [`MBT_UNITS-1:0] ext);
      return (kind == MBT_KIND_UNITVAL) ? ext[v[3:0]] : v;
   endfunction

   function automatic logic [17:0] to_byte(input logic direct, input logic [1:0] w, input mbt_val_t v);
      if (direct) begin
         return (18'(v) - 18'd1) << w;
      end
      return 18'(v);
   endfunction

   function automatic logic start_bad(input logic [1:0] kind, input logic [1:0] w, input mbt_val_t v,
                                      input logic [17:0] a);
      logic direct;
      direct = (kind == MBT_KIND_MARKER);
      return (kind == 2'b11) || (direct && (v == 16'h0000 || w == 2'b11)) || (a >= MEM_L);
   endfunction

   mbt_val_t sv, dv, cv;
   logic [17:0] sa, da, slen;
   logic s_bad, d_bad, c_bad, bad, rng, ovl;

   always_comb begin
      sv = pick_val(cfg.src_kind, opnd.src, ext_value);
      dv = pick_val(cfg.dst_kind, opnd.dst, ext_value);
      cv = (cfg.cnt_kind == MBT_KIND_MARKER) ? {8'h00, cnt_byte} : pick_val(cfg.cnt_kind, opnd.cnt, ext_value);
      // Direct marker number or byte offset from the first marker byte
      sa = to_byte(cfg.src_kind == MBT_KIND_MARKER, cfg.src_w, sv);
      da = to_byte(cfg.dst_kind == MBT_KIND_MARKER, cfg.dst_w, dv);
      s_bad = start_bad(cfg.src_kind, cfg.src_w, sv, sa);
      d_bad = start_bad(cfg.dst_kind, cfg.dst_w, dv, da);
      c_bad = (cv < `MBT_CNT_MIN) || (cv > `MBT_CNT_MAX) || (cfg.cnt_kind == 2'b11);
      // Count marker must exist
      if (cfg.cnt_kind == MBT_KIND_MARKER && (opnd.cnt == 16'h0000 || 18'(opnd.cnt) > MEM_L)) begin
         c_bad = 1'b1;
      end
      bad = s_bad || d_bad || c_bad;
      slen = cfg.copy ? 18'(cv) : 18'd1;
      rng = !bad && ((sa + slen > MEM_L) || (da + 18'(cv) > MEM_L));
      ovl = !bad && (sa < da + 18'(cv)) && (da < sa + slen);
   end

   assign err_now = bad || rng || ovl;
   assign src_addr = sa[AW-1:0];
   assign dst_addr = da[AW-1:0];
   assign len = cv[7:0];
   assign cnt_idx = AW'(opnd.cnt - 16'h0001);

   // Flags follow the settings every cycle, trigger or not
   always_ff @(posedge clk) begin
      if (srst) begin
         flags_q <= '0;
      end else begin
         flags_q <= '{range: rng, overlap: ovl, bad: bad};
      end
   end

endmodule

// >>> core/mbt_top.sv
`timescale 1ns/1ps
`include "mbt_cfg.svh"

// Contract
// - One fill or copy per rising trigger edge; steady trigger does nothing.
// - Byte, word and double-word marker starts all map to byte storage.
// - Up to sixteen units, each with own settings, trigger and flags.
// - Range flag when source or destination range runs past marker space.
// - Overlap flag when any source byte lies inside the destination range.
// - Bad-offset flag when an offset or count is outside its legal range.
// - Mode selects fill or copy; fill after reset.
// - Visibility setting allows parameter display; display allowed after reset.
// - Byte count per range is 1 to 192; anything else is an error.
// - Starts and count take a constant, marker value or unit value.
// - Direct marker operands give the marker's own location as start.
// - Constant or unit value is a byte offset from the first marker byte.
// - Any error flag blocks the transfer and leaves memory untouched.
// - Fill reads one source byte and writes it to every destination byte.
// - Error flags are evaluated continuously regardless of the trigger.
// - Copy moves each source byte to its matching destination byte.
// - Transfers are bytewise; wider markers are stored least significant byte first.
module mbt_top #(
   parameter int UNITS = `MBT_UNITS,
   parameter int MEM_BYTES = `MBT_MEM_BYTES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Unit triggers and values from other units
   input wire logic [UNITS-1:0] transfer_trigger,
   input wire mbt_pkg::mbt_val_t [`MBT_UNITS-1:0] unit_value_output,
   // Unit flags
   output logic [UNITS-1:0] range_exceeded_flag,
   output logic [UNITS-1:0] overlap_flag,
   output logic [UNITS-1:0] bad_offset_flag,
   output logic [UNITS-1:0] show_params,
   // Engine state
   output logic xfer_busy
);
   import mbt_pkg::*;

   // Byte address width of the marker memory
   localparam int AW = $clog2(MEM_BYTES);

   // Unit settings and results
   mbt_ctrl_t [UNITS-1:0] cfg_q;
   mbt_opnd_t [UNITS-1:0] opnd_q;
   // Registered flags, one cycle behind the settings
   mbt_flags_t [UNITS-1:0] flags;
   logic [UNITS-1:0] err_now;
   // Accepted edges waiting for the engine
   logic [UNITS-1:0] pend_q;
   // Per-unit byte addresses, length and count byte
   logic [AW-1:0] src_a [UNITS];
   logic [AW-1:0] dst_a [UNITS];
   logic [AW-1:0] cmi [UNITS];
   logic [7:0] len [UNITS];
   logic [7:0] cmb [UNITS];

   // Trigger synchroniser and edge detect
   logic [UNITS-1:0] trig_s1_q;
   logic [UNITS-1:0] trig_s2_q;
   logic [UNITS-1:0] trig_prev_q;
   logic [UNITS-1:0] trig_edge;

   // Marker memory
   // Not reset; loaded over the bus
   logic [7:0] mem_q [MEM_BYTES];

   // Engine
   mbt_state_t state_q;
   // Unit being served
   logic [3:0] act_q;
   logic [3:0] pick;
   logic any_pend;
   logic start_ok;
   logic go;
   logic drop;
   logic done;
   // Latched at start; later setting changes wait
   logic copy_q;
   logic [7:0] fill_q;
   logic [7:0] idx_q;
   logic [7:0] len_q;
   logic [AW-1:0] src_q;
   logic [AW-1:0] dst_q;
   logic busy_q;
   // Engine write port
   logic eng_we;
   logic [AW-1:0] eng_wa;
   logic [AW-1:0] eng_ra;
   logic [7:0] eng_wd;

   // APB
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   // Request decode
   logic acc;
   logic wr_fire;
   logic stat_hit;
   logic unit_hit;
   logic mem_hit;
   logic apb_stall;
   logic [3:0] u_sel;
   logic [1:0] r_sel;
   logic [15:0] m_ofs;
   logic [AW-1:0] m_sel;
   // Read mux and unmapped-word error
   logic [31:0] rd_data;
   logic rd_err;

   genvar g;
   generate
      for (g = 0; g < UNITS; g++) begin : gen_unit
         // Flag and address evaluation for one unit
         mbt_unit #(
            .MEM_BYTES(MEM_BYTES),
            .AW(AW)
         ) u_unit (
            .clk(clk),
            .srst(srst),
            .cfg(cfg_q[g]),
            .opnd(opnd_q[g]),
            .ext_value(unit_value_output),
            .cnt_byte(cmb[g]),
            .cnt_idx(cmi[g]),
            .src_addr(src_a[g]),
            .dst_addr(dst_a[g]),
            .len(len[g]),
            .flags_q(flags[g]),
            .err_now(err_now[g])
         );
         // Count taken from a marker byte
         assign cmb[g] = mem_q[cmi[g]];
         assign range_exceeded_flag[g] = flags[g].range;
         assign overlap_flag[g] = flags[g].overlap;
         assign bad_offset_flag[g] = flags[g].bad;
         assign show_params[g] = cfg_q[g].show;
      end
   endgenerate

   // Address decode
   assign acc = psel & penable;
   // Write lands on the ready edge
   assign wr_fire = acc & pready_q & pwrite;
   assign u_sel = paddr[7:4];
   assign r_sel = paddr[3:2];
   // Word index inside the memory window
   assign m_ofs = paddr - `MBT_MEM_BASE;
   assign m_sel = m_ofs[AW+1:2];
   // Status word, unit pages, memory window
   assign stat_hit = (paddr == `MBT_STATUS_OFS);
   assign unit_hit = (paddr[15:8] == `MBT_UNIT_PAGE) && (paddr[1:0] == 2'b00) && (32'(u_sel) < UNITS);
   // One marker byte per aligned word
   assign mem_hit = (paddr >= `MBT_MEM_BASE) && (32'(m_ofs) < 4 * MEM_BYTES) && (paddr[1:0] == 2'b00);
   // Memory accesses wait while the engine owns the write port
   assign apb_stall = mem_hit & ((state_q == MBT_MOVE) | go);

   // Unused read bits return zero
   always_comb begin
      rd_data = 32'h0000_0000;
      rd_err = 1'b0;
      if (stat_hit) begin
         rd_data = {16'(pend_q), 8'h00, act_q, 3'b000, busy_q};
      end else if (unit_hit) begin
         unique case (r_sel)
            `MBT_REG_CTRL: rd_data = {13'h0000, flags[u_sel], 4'h0, cfg_q[u_sel]};
            `MBT_REG_SRC: rd_data = {16'h0000, opnd_q[u_sel].src};
            `MBT_REG_DST: rd_data = {16'h0000, opnd_q[u_sel].dst};
            `MBT_REG_CNT: rd_data = {16'h0000, opnd_q[u_sel].cnt};
         endcase
      end else if (mem_hit) begin
         rd_data = {24'h00_0000, mem_q[m_sel]};
      end else begin
         rd_err = 1'b1;
      end
   end

   // APB answer: ready one cycle after the access phase starts
   always_ff @(posedge clk) begin
      if (srst) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else if (pready_q) begin
         // Ready, error and data last one cycle
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else if (acc && !apb_stall) begin
         // Writes answer with zero data
         pready_q <= 1'b1;
         pslverr_q <= rd_err;
         prdata_q <= pwrite ? 32'h0000_0000 : rd_data;
      end
   end

   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign prdata = prdata_q;

   // Unit settings
   always_ff @(posedge clk) begin
      if (srst) begin
         for (int i = 0; i < UNITS; i++) begin
            cfg_q[i] <= mbt_ctrl_t'(`MBT_CTRL_RST);
            opnd_q[i] <= '0;
         end
      end else if (wr_fire && unit_hit) begin
         // Status page and flag bits are read only
         unique case (r_sel)
            `MBT_REG_CTRL: cfg_q[u_sel] <= mbt_ctrl_t'(pwdata[`MBT_CTRL_W-1:0]);
            `MBT_REG_SRC: opnd_q[u_sel].src <= pwdata[15:0];
            `MBT_REG_DST: opnd_q[u_sel].dst <= pwdata[15:0];
            `MBT_REG_CNT: opnd_q[u_sel].cnt <= pwdata[15:0];
         endcase
      end
   end

   // Trigger pins
   always_ff @(posedge clk) begin
      if (srst) begin
         trig_s1_q <= '0;
         trig_s2_q <= '0;
         trig_prev_q <= '0;
      end else begin
         // Two stages against metastability
         trig_s1_q <= transfer_trigger;
         trig_s2_q <= trig_s1_q;
         trig_prev_q <= trig_s2_q;
      end
   end

   // Rising edge of the synchronised pin
   assign trig_edge = trig_s2_q & ~trig_prev_q;

   // Lowest pending unit is served first
   always_comb begin
      pick = 4'h0;
      for (int i = UNITS - 1; i >= 0; i--) begin
         if (pend_q[i]) begin
            pick = 4'(i);
         end
      end
   end

   assign any_pend = |pend_q;
   // No start while a memory-window answer is out
   assign start_ok = (state_q == MBT_IDLE) && any_pend && !(pready_q && mem_hit);
   // Units with errors are dropped without a write
   assign go = start_ok && !err_now[pick];
   assign drop = start_ok && err_now[pick];
   // Last byte index of the running transfer
   assign done = (state_q == MBT_MOVE) && (idx_q == len_q - 8'h01);

   // Accepted edges; a pending unit ignores edges until its transfer ends
   always_ff @(posedge clk) begin
      if (srst) begin
         pend_q <= '0;
      end else begin
         for (int i = 0; i < UNITS; i++) begin
            // Finish or drop clears; an edge while pending is lost
            if ((done && act_q == 4'(i)) || (drop && pick == 4'(i))) begin
               pend_q[i] <= 1'b0;
            end else if (trig_edge[i] && !err_now[i]) begin
               pend_q[i] <= 1'b1;
            end
         end
      end
   end

   // Engine sequencing
   always_ff @(posedge clk) begin
      if (srst) begin
         state_q <= MBT_IDLE;
         act_q <= 4'h0;
         idx_q <= 8'h00;
         len_q <= 8'h00;
         src_q <= '0;
         dst_q <= '0;
         copy_q <= 1'b0;
         fill_q <= 8'h00;
         busy_q <= 1'b0;
      end else begin
         // Settings and addresses are frozen at start
         unique case (state_q)
            MBT_IDLE: begin
               if (go) begin
                  state_q <= MBT_MOVE;
                  busy_q <= 1'b1;
                  act_q <= pick;
                  idx_q <= 8'h00;
                  len_q <= len[pick];
                  src_q <= src_a[pick];
                  dst_q <= dst_a[pick];
                  copy_q <= cfg_q[pick].copy;
                  // Single source byte for fill
                  fill_q <= mem_q[src_a[pick]];
               end
            end
            MBT_MOVE: begin
               // One byte per cycle, ascending
               idx_q <= idx_q + 8'h01;
               if (done) begin
                  state_q <= MBT_IDLE;
                  busy_q <= 1'b0;
               end
            end
         endcase
      end
   end

   assign xfer_busy = busy_q;

   // Copy reads the matching source byte, fill repeats the latched one
   always_comb begin
      eng_we = (state_q == MBT_MOVE);
      eng_wa = AW'(dst_q + AW'(idx_q));
      eng_ra = AW'(src_q + AW'(idx_q));
      eng_wd = copy_q ? mem_q[eng_ra] : fill_q;
   end

   // Marker memory writes: engine first, APB when engine is idle
   always_ff @(posedge clk) begin
      if (eng_we) begin
         mem_q[eng_wa] <= eng_wd;
      end else if (wr_fire && mem_hit) begin
         mem_q[m_sel] <= pwdata[7:0];
      end
   end

endmodule

// >>> bench/mbt_sva.sv
`timescale 1ns/1ps
module mbt_sva #(
   parameter int UNITS = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Bus
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Units
   input wire logic [UNITS-1:0] transfer_trigger,
   input wire logic [UNITS-1:0] range_exceeded_flag,
   input wire logic [UNITS-1:0] overlap_flag,
   input wire logic [UNITS-1:0] bad_offset_flag,
   input wire logic [UNITS-1:0] show_params,
   input wire logic xfer_busy
);
   logic [UNITS-1:0] trig_q;
   logic [11:0] idle_q;
   logic [7:0] run_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   always_ff @(posedge clk) begin
      trig_q <= srst ? '0 : transfer_trigger;
   end
   // Cycles since the last trigger rise, saturating
   always_ff @(posedge clk) begin
      if (srst || (transfer_trigger & ~trig_q) != '0) begin
         idle_q <= 12'h000;
      end else if (idle_q != 12'hfff) begin
         idle_q <= idle_q + 12'h001;
      end
   end
   always_ff @(posedge clk) begin
      run_q <= (srst || !xfer_busy) ? 8'h00 : run_q + 8'h01;
   end
   AST_BUSY_CAUSE: assert property ($rose(xfer_busy) |-> idle_q < 12'hfff) else $error("busy without edge");
   AST_BUSY_LEN: assert property (run_q <= 8'hc0) else $error("transfer too long");
   AST_ERR_EXCL: assert property ((bad_offset_flag & (range_exceeded_flag | overlap_flag)) == '0)
      else $error("flags not exclusive");
   AST_RST_BAD: assert property ($fell(srst) |-> ##[0:2] (bad_offset_flag == '1)) else $error("flags idle");
   AST_RST_SHOW: assert property ($past(srst) |-> show_params == '1 && !xfer_busy) else $error("reset view");
   AST_READY_PULSE: assert property (pready |=> !pready) else $error("ready too long");
   AST_READY_ACC: assert property (pready |-> psel && penable) else $error("ready outside access");
   AST_ERR_READY: assert property (pslverr |-> pready) else $error("error without ready");
   AST_WAIT_BOUND: assert property (psel && penable && !pready |-> ##[1:400] pready) else $error("no answer");
   AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0) else $error("stale read data");
   COV_RUN: cover property ($rose(xfer_busy));
   COV_SLV: cover property (pslverr);
   COV_OVL: cover property (overlap_flag != '0);
   COV_RNG: cover property (range_exceeded_flag != '0);
endmodule
bind mbt_top mbt_sva #(.UNITS(UNITS)) sva_u (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .transfer_trigger(transfer_trigger),
   .range_exceeded_flag(range_exceeded_flag), .overlap_flag(overlap_flag),
   .bad_offset_flag(bad_offset_flag), .show_params(show_params), .xfer_busy(xfer_busy));

// >>> bench/mbt_far.sv
`timescale 1ns/1ps
module mbt_far (
   // Clock
   input wire logic clk,
   // Bench requests
   input wire logic [15:0] fire,
   // Program side
   output logic [15:0] transfer_trigger,
   output mbt_pkg::mbt_val_t [15:0] unit_value_output
);
   import mbt_pkg::*;
   always_ff @(posedge clk) begin
      transfer_trigger <= fire;
   end
   // Unit i offers the offset of word marker i+1
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         unit_value_output[i] = mbt_val_t'(i * 2);
      end
   end
endmodule

// >>> bench/tb.sv
`timescale 1ns/1ps
module tb;
   import mbt_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [15:0] fire = 16'h0000;
   logic [15:0] trig;
   mbt_val_t [15:0] uvo;
   logic [15:0] rng, ovl, bad, shw;
   logic busy;
   logic [31:0] r;
   logic e;
   int fails = 0;
   int check_count = 0;
   int tm[10] = '{1, 1, 1, 0, 1, 1, 1, 1, 3073, 0};
   int ts[10] = '{0, 0, 0, 0, 500, 512, 100, 100, 0, 100};
   int td[10] = '{200, 200, 200, 400, 0, 0, 103, 104, 200, 100};
   int tn[10] = '{193, 0, 192, 192, 16, 16, 4, 4, 4, 4};
   int tx[10] = '{1, 1, 0, 4, 4, 1, 2, 0, 1, 2};
   always #12.5 clk = ~clk;
   mbt_top dut_u (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .transfer_trigger(trig),
      .unit_value_output(uvo), .range_exceeded_flag(rng), .overlap_flag(ovl), .bad_offset_flag(bad),
      .show_params(shw), .xfer_busy(busy));
   mbt_far far_u (.clk(clk), .fire(fire), .transfer_trigger(trig), .unit_value_output(uvo));
   function automatic logic [15:0] ua(input int n, input int k);
      return 16'h0100 + 16'(n * 16 + k * 4);
   endfunction
   function automatic logic [15:0] ma(input int i);
      return 16'h1000 + 16'(i * 4);
   endfunction
   task automatic close_out();
      $display("checks=%0d fails=%0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      check_count++;
      if (g !== x) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 500);
      if (n >= 500) begin
         fails++;
         close_out();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(r, x);
   endtask
   task automatic cfg(input int u, input int c, input int s, input int d, input int n);
      wr(ua(u, 1), 32'(s));
      wr(ua(u, 2), 32'(d));
      wr(ua(u, 3), 32'(n));
      wr(ua(u, 0), 32'(c));
      repeat (2) @(posedge clk);
   endtask
   // Sets the trigger level and waits for a whole transfer, or for none
   task automatic trig_to(input int u, input logic lvl, input logic run);
      logic seen;
      seen = 1'b0;
      fire[u] <= lvl;
      for (int k = 0; k < 300 && !(seen && busy === 1'b0); k++) begin
         @(posedge clk);
         if (busy === 1'b1) seen = 1'b1;
      end
      chk({31'h0, seen}, {31'h0, run});
   endtask
   initial begin
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      repeat (3) @(posedge clk);
      rd(ua(0, 0), 32'h0001_0002);
      chk({16'h0, shw}, 32'h0000_ffff);
      chk({16'h0, bad}, 32'h0000_ffff);
      apb(1'b0, 16'h0800, 32'h0);
      chk({31'h0, e}, 32'h1);
      // Fill from marker byte 10 to offset 64
      wr(ma(9), 32'h2d);
      for (int k = 64; k < 69; k++) wr(ma(k), 32'h0);
      cfg(0, 32'h004, 10, 64, 4);
      chk({16'h0, shw}, 32'h0000_fffe);
      trig_to(0, 1'b1, 1'b1);
      for (int k = 64; k < 68; k++) rd(ma(k), 32'h2d);
      rd(ma(68), 32'h0);
      // Steady and falling trigger do nothing
      wr(ma(9), 32'h11);
      trig_to(0, 1'b1, 1'b0);
      trig_to(0, 1'b0, 1'b0);
      rd(ma(64), 32'h2d);
      // Copy six bytes onto double-word marker 80 and half of 81
      for (int k = 0; k < 6; k++) wr(ma(59 + k), 32'(8'h31 + k));
      wr(ma(322), 32'h0);
      cfg(1, 32'h245, 60, 80, 6);
      trig_to(1, 1'b1, 1'b1);
      for (int k = 0; k < 6; k++) rd(ma(316 + k), 32'(8'h31 + k));
      rd(ma(322), 32'h0);
      // Last unit, destination from another unit's value
      wr(ma(6), 32'h0);
      wr(ma(7), 32'h0);
      cfg(15, 32'h082, 9, 3, 1);
      trig_to(15, 1'b1, 1'b1);
      rd(ma(6), 32'h11);
      rd(ma(7), 32'h0);
      // Error table on unit 2
      for (int i = 0; i < 10; i++) begin
         cfg(2, tm[i], ts[i], td[i], tn[i]);
         chk({29'h0, rng[2], ovl[2], bad[2]}, 32'(tx[i]));
      end
      rd(ua(2, 0), 32'h0002_0000);
      wr(ma(100), 32'h5a);
      wr(ma(101), 32'h0);
      trig_to(2, 1'b1, 1'b0);
      rd(ma(101), 32'h0);
      trig_to(2, 1'b0, 1'b0);
      close_out();
   end
endmodule
